// ==== design/ioc_div_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Divider control and its resulting tick
interface ioc_div_if;
  logic run;
  ioc_pkg::ioc_div_t div;
  logic tick;
  modport ctrl (output run, output div, input tick);
  modport divider (input run, input div, output tick);
endinterface
`default_nettype wire

// ==== design/ioc_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
// Divides the oscillator clock by 1, 2, 4 or 8 into a one-cycle tick
module ioc_divider (
  input wire logic clk_sys,
  input wire logic reset_n,
  ioc_div_if.divider dif
);
  logic [2:0] count;

  // Free counter, held at zero while the oscillator is stopped
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= 3'h0;
    end else if (!dif.run) begin
      count <= 3'h0;
    end else begin
      count <= count + 3'h1;
    end
  end

  // Tick when the low bits for the chosen ratio are all ones
  always_comb begin
    case (dif.div)
      ioc_pkg::IOC_DIV1: dif.tick = dif.run;
      ioc_pkg::IOC_DIV2: dif.tick = dif.run & count[0];
      ioc_pkg::IOC_DIV4: dif.tick = dif.run & (&count[1:0]);
      default: dif.tick = dif.run & (&count);
    endcase
  end
endmodule
`default_nettype wire

// ==== design/ioc_pkg.sv ====
`default_nettype none
package ioc_pkg;
  typedef enum logic [1:0] {
    IOC_DIV8 = 2'b00,
    IOC_DIV4 = 2'b01,
    IOC_DIV2 = 2'b10,
    IOC_DIV1 = 2'b11
  } ioc_div_t;

  typedef enum logic [1:0] {
    IOC_SRC_INT = 2'b00,
    IOC_SRC_EXT = 2'b01,
    IOC_SRC_MUL = 2'b10
  } ioc_src_t;

  typedef enum logic [2:0] {
    IOC_ST_OFF = 3'b001,
    IOC_ST_SETTLE = 3'b010,
    IOC_ST_RUN = 3'b100
  } ioc_state_t;
endpackage
`default_nettype wire

// ==== design/ioc_regs.svh ====
`ifndef IOC_REGS_SVH
`define IOC_REGS_SVH

// Register indices of the control and calibration registers; one aligned word each
`define IOC_IDX_CTRL 12'h0b2
`define IOC_IDX_CAL 12'h0b3
// Byte addresses on the register bus are four times the index
`define IOC_ADDR_CTRL (`IOC_IDX_CTRL << 2)
`define IOC_ADDR_CAL (`IOC_IDX_CAL << 2)
// Added registers sit at free word addresses of their own
`define IOC_ADDR_SEL 12'h0c0
`define IOC_ADDR_STAT 12'h0c4
`define IOC_ADDR_MASK 12'h0c8

// Control register fields
`define IOC_CTRL_EN_BIT 7
`define IOC_CTRL_RDY_BIT 6
`define IOC_CTRL_SUSP_BIT 5
`define IOC_CTRL_RESET 8'h80

// Calibration field is bits 4..0
`define IOC_CAL_MSB 4
`define IOC_CAL_RESET 5'h10

// Clock select register: [1:0] system source, [3:2] usb source, [4] vbus polarity
`define IOC_SEL_RESET 8'h00

// Status bits: 0 resume event, 1 vbus wake event
`define IOC_STAT_RESUME 0
`define IOC_STAT_VBUS 1

// Oscillator settle time after start, in ns, and the derived cycle count
`define IOC_SETTLE_NS 200
`define IOC_CLK_NS 10
`define IOC_SETTLE_CYC ((`IOC_SETTLE_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)

`endif

// ==== design/ioc_top.sv ====
// What this block does
// - After reset the internal oscillator is the system clock source
// - System clock is oscillator divided by one, two, four or eight
// - Divider resets to divide by eight
// - Control bit 7 enables the oscillator, read and write
// - Control bit 6 reads one only while running at programmed frequency
// - Writing one to control bit 5 stops the oscillator into suspend
// - A non-idle USB event restarts a suspended oscillator
// - VBUS at the selected polarity restarts a suspended oscillator
// - Non-idle bus detection keeps working while the transceiver is suspended
// - Non-idle USB event raises resume interrupt; software then re-enables transceiver
// - Each calibration step changes period by about 0.0025 of base period
// - Calibration resets to the factory value giving 12 MHz
// - Any reset reloads the factory calibration value
// - System clock selectable from internal, external, or multiplier divided by 2
// - USB clock selectable from internal, external, or multiplier
// - Calibration value occupies bits 4 to 0 and sets the period
`timescale 1ns/1ps
`default_nettype none
`include "ioc_regs.svh"
module ioc_top #(
  parameter logic [4:0] FACTORY_CAL = `IOC_CAL_RESET
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usb_nonidle,
  input wire logic vbus_level,
  output logic osc_running,
  output logic sys_clk_tick,
  output logic [1:0] sys_clk_src,
  output logic [1:0] usb_clk_src,
  output logic [4:0] osc_trim,
  output logic irq
);
  logic [7:0] ctrl;
  logic [4:0] cal;
  logic [7:0] clk_sel;
  logic [1:0] stat;
  logic [1:0] mask;
  logic suspended;
  logic freq_ready;
  logic [7:0] settle_cnt;
  logic wr_en;
  logic rd_en;
  logic wake_usb;
  logic wake_vbus;
  logic [1:0] next_stat;
  ioc_pkg::ioc_state_t state;
  ioc_pkg::ioc_state_t next_state;
  ioc_div_if dif ();

  // Access phase with the slave always ready: one wait-free cycle per transfer
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  // Wake conditions; usb_nonidle comes from the always-on detector
  assign wake_usb = usb_nonidle;
  assign wake_vbus = (vbus_level == clk_sel[4]);

  // Control register: enable and divider stored, suspend is a command bit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `IOC_CTRL_RESET;
    end else if (wr_en && paddr == `IOC_ADDR_CTRL) begin
      ctrl <= {pwdata[7], 5'h00, pwdata[1:0]};
    end
  end

  // Suspend is set by a write of one and cleared by either wake source
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      suspended <= 1'b0;
    end else if (wr_en && paddr == `IOC_ADDR_CTRL && pwdata[`IOC_CTRL_SUSP_BIT]) begin
      suspended <= 1'b1;
    end else if (suspended && (wake_usb || wake_vbus)) begin
      suspended <= 1'b0;
    end
  end

  // Calibration: reloads the factory value on every reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cal <= FACTORY_CAL;
    end else if (wr_en && paddr == `IOC_ADDR_CAL) begin
      cal <= pwdata[`IOC_CAL_MSB:0];
    end
  end

  // Source select; reset picks the internal oscillator for both clocks
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clk_sel <= `IOC_SEL_RESET;
    end else if (wr_en && paddr == `IOC_ADDR_SEL) begin
      clk_sel <= {3'h0, pwdata[4:0]};
    end
  end

  // Mask register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mask <= 2'h0;
    end else if (wr_en && paddr == `IOC_ADDR_MASK) begin
      mask <= pwdata[1:0];
    end
  end

  // Sticky events; a new event wins over a write-one clear in the same cycle
  always_comb begin
    next_stat = stat;
    if (wr_en && paddr == `IOC_ADDR_STAT) begin
      next_stat = stat & ~pwdata[1:0];
    end
    if (wake_usb) begin
      next_stat[`IOC_STAT_RESUME] = 1'b1;
    end
    if (suspended && wake_vbus) begin
      next_stat[`IOC_STAT_VBUS] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stat <= 2'h0;
    end else begin
      stat <= next_stat;
    end
  end

  // Oscillator state: off, settling after start, then at frequency
  always_comb begin
    case (state)
      ioc_pkg::IOC_ST_OFF: begin
        next_state = (ctrl[`IOC_CTRL_EN_BIT] && !suspended) ?
          ioc_pkg::IOC_ST_SETTLE : ioc_pkg::IOC_ST_OFF;
      end
      ioc_pkg::IOC_ST_SETTLE: begin
        if (!ctrl[`IOC_CTRL_EN_BIT] || suspended) begin
          next_state = ioc_pkg::IOC_ST_OFF;
        end else if (settle_cnt == 8'(`IOC_SETTLE_CYC - 1)) begin
          next_state = ioc_pkg::IOC_ST_RUN;
        end else begin
          next_state = ioc_pkg::IOC_ST_SETTLE;
        end
      end
      ioc_pkg::IOC_ST_RUN: begin
        next_state = (!ctrl[`IOC_CTRL_EN_BIT] || suspended) ?
          ioc_pkg::IOC_ST_OFF : ioc_pkg::IOC_ST_RUN;
      end
      default: next_state = ioc_pkg::IOC_ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ioc_pkg::IOC_ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Settle counter also restarts after a trim change, since the period moves
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      settle_cnt <= 8'h00;
    end else if (state != ioc_pkg::IOC_ST_SETTLE || (wr_en && paddr == `IOC_ADDR_CAL)) begin
      settle_cnt <= 8'h00;
    end else begin
      settle_cnt <= settle_cnt + 8'h01;
    end
  end

  // Ready only in the run state with no trim write pending
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      freq_ready <= 1'b0;
    end else begin
      freq_ready <= (next_state == ioc_pkg::IOC_ST_RUN) &&
        !(wr_en && paddr == `IOC_ADDR_CAL);
    end
  end

  // Divider runs only while the oscillator runs
  assign dif.run = (state == ioc_pkg::IOC_ST_RUN);
  assign dif.div = ioc_pkg::ioc_div_t'(ctrl[1:0]);

  ioc_divider u_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .dif(dif)
  );

  // Registered outputs; trim passes the period step to the analog cell
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sys_clk_tick <= 1'b0;
      osc_running <= 1'b0;
      sys_clk_src <= 2'h0;
      usb_clk_src <= 2'h0;
      osc_trim <= FACTORY_CAL;
      irq <= 1'b0;
    end else begin
      sys_clk_tick <= dif.tick;
      osc_running <= dif.run;
      sys_clk_src <= clk_sel[1:0];
      usb_clk_src <= clk_sel[3:2];
      osc_trim <= cal;
      irq <= |(next_stat & mask);
    end
  end

  // Read mux; unmapped addresses read zero and raise pslverr
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `IOC_ADDR_CTRL: prdata <= {24'h00_0000, ctrl[7], freq_ready, 4'h0, ctrl[1:0]};
          `IOC_ADDR_CAL: prdata <= {27'h000_0000, cal};
          `IOC_ADDR_SEL: prdata <= {24'h00_0000, clk_sel};
          `IOC_ADDR_STAT: prdata <= {30'h0000_0000, stat};
          `IOC_ADDR_MASK: prdata <= {30'h0000_0000, mask};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Named steps of starting, settling and suspending the oscillator
  sequence s_start;
    state == ioc_pkg::IOC_ST_OFF && next_state == ioc_pkg::IOC_ST_SETTLE;
  endsequence

  sequence s_settled;
    state == ioc_pkg::IOC_ST_SETTLE && next_state == ioc_pkg::IOC_ST_RUN &&
      !(wr_en && paddr == `IOC_ADDR_CAL);
  endsequence

  sequence s_suspend_write;
    wr_en && paddr == `IOC_ADDR_CTRL && pwdata[`IOC_CTRL_SUSP_BIT];
  endsequence

  // Ready flag tracks the run state; a trim write costs it one cycle
  a_ready_needs_run: assert property (@(posedge clk_sys) disable iff (!reset_n)
    freq_ready |-> state == ioc_pkg::IOC_ST_RUN)
    else $error("ready flag set while oscillator not running");
  a_ready_on_settle: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_settled |=> freq_ready)
    else $error("ready flag not set after settling");
  a_ready_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (psel && !penable && paddr == `IOC_ADDR_CTRL) |=> prdata[6] == $past(freq_ready))
    else $error("ready flag read back wrong");

  // Suspend stops the oscillator and the divider behind it
  a_suspend_stops: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_suspend_write |=> suspended ##1 !freq_ready)
    else $error("suspend write did not stop oscillator");
  a_suspend_no_run: assert property (@(posedge clk_sys) disable iff (!reset_n)
    suspended |=> !dif.run)
    else $error("oscillator ran while suspended");
  a_suspend_reads_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (psel && !penable && paddr == `IOC_ADDR_CTRL) |=> !prdata[`IOC_CTRL_SUSP_BIT])
    else $error("suspend command bit read back as one");
  a_enable_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !ctrl[`IOC_CTRL_EN_BIT] |=> state == ioc_pkg::IOC_ST_OFF)
    else $error("disabled oscillator kept running");
  a_settle_time: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_start ##1 (ctrl[7] && !suspended && !wr_en) [*8] |-> state != ioc_pkg::IOC_ST_OFF)
    else $error("enabled oscillator fell back to off");

  // Wake sources; the detector stays alive while the transceiver sleeps
  a_wake_usb: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (suspended && usb_nonidle && !(wr_en && paddr == `IOC_ADDR_CTRL)) |=> !suspended)
    else $error("usb activity did not wake oscillator");
  a_wake_vbus: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (suspended && vbus_level == clk_sel[4] && !wr_en) |=> !suspended)
    else $error("vbus did not wake oscillator");
  a_vbus_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (suspended && vbus_level == clk_sel[4]) |=> stat[`IOC_STAT_VBUS])
    else $error("vbus wake status not set");
  a_wake_restart: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($fell(suspended) && ctrl[`IOC_CTRL_EN_BIT]) |-> next_state == ioc_pkg::IOC_ST_SETTLE)
    else $error("wake did not restart the oscillator");

  // Resume event and interrupt; set wins over a clear in the same cycle
  a_resume_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    usb_nonidle |=> stat[`IOC_STAT_RESUME])
    else $error("resume status not set");
  a_resume_irq: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (usb_nonidle && mask[`IOC_STAT_RESUME]) |=> irq)
    else $error("unmasked resume did not raise interrupt");
  a_irq_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq == |(stat & $past(mask)))
    else $error("interrupt level does not match unmasked status");

  // Divider spacing; the checks tolerate a ratio change in mid-window
  a_div8_tick: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dif.tick && ctrl[1:0] == 2'b00 && $stable(ctrl)) |=>
      (!dif.tick || ctrl[1:0] != 2'b00) [*7])
    else $error("divide by eight tick spacing wrong");
  a_div2_tick: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dif.tick && ctrl[1:0] == 2'b10) |=> (!dif.tick || ctrl[1:0] != 2'b10))
    else $error("divide by two tick spacing wrong");
  a_div1_tick: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dif.run && ctrl[1:0] == 2'b11) |-> dif.tick)
    else $error("divide by one missed a tick");
  a_tick_needs_run: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sys_clk_tick |-> osc_running)
    else $error("system clock tick while oscillator stopped");

  // Register paths to the outputs
  a_cal_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wr_en && paddr == `IOC_ADDR_CAL) |=> cal == $past(pwdata[`IOC_CAL_MSB:0]))
    else $error("calibration write not stored");
  a_trim_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
    osc_trim == $past(cal))
    else $error("trim output does not follow calibration");
  a_sys_src: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sys_clk_src == $past(clk_sel[1:0]))
    else $error("system clock source output wrong");
  a_usb_src: assert property (@(posedge clk_sys) disable iff (!reset_n)
    usb_clk_src == $past(clk_sel[3:2]))
    else $error("usb clock source output wrong");

  // Defaults seen at the first edge after any reset
  a_cal_reset: assert property (@(posedge clk_sys)
    $rose(reset_n) |-> cal == FACTORY_CAL)
    else $error("calibration not reloaded by reset");
  a_div_reset: assert property (@(posedge clk_sys)
    $rose(reset_n) |-> ctrl == `IOC_CTRL_RESET)
    else $error("control register not at reset value");
  a_src_reset: assert property (@(posedge clk_sys)
    $rose(reset_n) |-> clk_sel[1:0] == ioc_pkg::IOC_SRC_INT)
    else $error("system clock source not internal after reset");
endmodule
`default_nettype wire

// ==== verif/ioc_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ioc_regs.svh"
module ioc_top_tb_top;
  typedef struct {logic [1:0] code; int period;} ioc_row_t;
  logic clk_sys, reset_n, psel, penable, pwrite, usb_nonidle, vbus_level;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, osc_running, sys_clk_tick, irq, err;
  logic [1:0] sys_clk_src, usb_clk_src;
  logic [4:0] osc_trim;
  int failures = 0;
  int n_tests = 0;
  int p;
  // Divider code against clk_sys cycles between two system clock ticks
  ioc_row_t rows [4] = '{'{2'b00, 8}, '{2'b01, 4}, '{2'b10, 2}, '{2'b11, 1}};

  ioc_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .usb_nonidle(usb_nonidle), .vbus_level(vbus_level),
    .osc_running(osc_running), .sys_clk_tick(sys_clk_tick), .sys_clk_src(sys_clk_src),
    .usb_clk_src(usb_clk_src), .osc_trim(osc_trim), .irq(irq));

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    n = 1;
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    chk("pready", {31'h0, pready}, 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait for the oscillator run flag to reach a level
  task automatic wait_run(input logic v, input int lim);
    int n;
    n = 0;
    while (osc_running !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk("osc_running", {31'h0, osc_running}, {31'h0, v});
  endtask

  // Cycles between two ticks; first tick found before counting
  task automatic measure(output int q);
    int n;
    n = 0;
    while (sys_clk_tick !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    q = 1;
    while (sys_clk_tick !== 1'b1 && q < 20) begin
      @(posedge clk_sys);
      q++;
    end
  endtask

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
  endtask

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #50000;
    failures++;
    tally_and_finish();
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    usb_nonidle = 1'b0;
    vbus_level = 1'b0;
    do_reset();
    chk("trim", {27'h0, osc_trim}, 32'h0000_0010);
    chk("sys src", {30'h0, sys_clk_src}, 32'h0000_0000);
    apb(1'b0, `IOC_ADDR_CTRL, 32'h0000_0000);
    chk("ctrl rst", rd, 32'h0000_0080);
    apb(1'b0, `IOC_ADDR_CAL, 32'h0000_0000);
    chk("cal rst", rd, 32'h0000_0010);
    wait_run(1'b1, 40);
    apb(1'b0, `IOC_ADDR_CTRL, 32'h0000_0000);
    chk("ctrl ready", rd, 32'h0000_00c0);
    // Every divider code: tick spacing and read-back
    foreach (rows[i]) begin
      apb(1'b1, `IOC_ADDR_CTRL, {30'h0, rows[i].code} | 32'h0000_0080);
      repeat (10) @(posedge clk_sys);
      measure(p);
      chk("tick period", p, rows[i].period);
      apb(1'b0, `IOC_ADDR_CTRL, 32'h0000_0000);
      chk("div code", rd & 32'h0000_0083, {30'h0, rows[i].code} | 32'h0000_0080);
    end
    apb(1'b1, `IOC_ADDR_CAL, 32'h0000_001f);
    // Trim output is registered behind the calibration register
    repeat (2) @(posedge clk_sys);
    chk("trim max", {27'h0, osc_trim}, 32'h0000_001f);
    apb(1'b0, `IOC_ADDR_CAL, 32'h0000_0000);
    chk("cal rb", rd, 32'h0000_001f);
    wait_run(1'b1, 40);
    // Polarity high so the idle low VBUS does not wake
    // USB clock moved off the retuned oscillator
    apb(1'b1, `IOC_ADDR_SEL, 32'h0000_0016);
    repeat (2) @(posedge clk_sys);
    chk("sys src", {30'h0, sys_clk_src}, 32'h0000_0002);
    chk("usb src", {30'h0, usb_clk_src}, 32'h0000_0001);
    apb(1'b1, `IOC_ADDR_CTRL, 32'h0000_00a3);
    wait_run(1'b0, 5);
    apb(1'b0, `IOC_ADDR_CTRL, 32'h0000_0000);
    chk("ctrl susp", rd, 32'h0000_0083);
    repeat (30) @(posedge clk_sys);
    chk("still off", {31'h0, osc_running}, 32'h0000_0000);
    usb_nonidle <= 1'b1;
    repeat (2) @(posedge clk_sys);
    usb_nonidle <= 1'b0;
    wait_run(1'b1, 30);
    apb(1'b0, `IOC_ADDR_STAT, 32'h0000_0000);
    chk("stat usb", rd, 32'h0000_0001);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `IOC_ADDR_MASK, 32'h0000_0003);
    repeat (2) @(posedge clk_sys);
    chk("irq on", {31'h0, irq}, 32'h0000_0001);
    apb(1'b1, `IOC_ADDR_STAT, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    chk("irq clr", {31'h0, irq}, 32'h0000_0000);
    // Wake from VBUS at the selected polarity
    apb(1'b1, `IOC_ADDR_CTRL, 32'h0000_00a3);
    wait_run(1'b0, 5);
    vbus_level <= 1'b1;
    wait_run(1'b1, 30);
    apb(1'b0, `IOC_ADDR_STAT, 32'h0000_0000);
    chk("stat vbus", rd, 32'h0000_0002);
    apb(1'b1, `IOC_ADDR_CTRL, 32'h0000_0003);
    wait_run(1'b0, 5);
    apb(1'b0, `IOC_ADDR_CTRL, 32'h0000_0000);
    chk("ctrl off", rd, 32'h0000_0003);
    apb(1'b0, 12'h0d0, 32'h0000_0000);
    chk("unmapped data", rd, 32'h0000_0000);
    chk("unmapped err", {31'h0, err}, 32'h0000_0001);
    // Reset in mid-run restores the factory trim and defaults
    do_reset();
    chk("trim again", {27'h0, osc_trim}, 32'h0000_0010);
    chk("src again", {30'h0, sys_clk_src}, 32'h0000_0000);
    apb(1'b0, `IOC_ADDR_CTRL, 32'h0000_0000);
    chk("ctrl again", rd, 32'h0000_0080);
    tally_and_finish();
  end
endmodule
`default_nettype wire
